// ==== hdl/eeprom_sel_pkg.sv ====
// constants and types for the serial eeprom select/output control block
package eeprom_sel_pkg;
  localparam int unsigned SYS_CLK_HZ    = 200_000_000;
  localparam int unsigned WRITE_TIME_MS = 6;
  localparam int unsigned WRITE_CYCLES  = SYS_CLK_HZ / 1000 * WRITE_TIME_MS;
  localparam int unsigned CNT_W         = 24;
  localparam int unsigned BIT_CNT_W     = 3;
  localparam logic [2:0]  BIT_CNT_RST   = 3'h0;
  localparam logic [7:0]  BYTE_RST      = 8'h00;
  localparam logic [7:0]  CMD_WRITE_EN  = 8'h06;
  localparam logic [7:0]  CMD_WRITE_DIS = 8'h04;
  localparam logic [7:0]  CMD_WRITE     = 8'h02;
  localparam logic [7:0]  CMD_WRITE_SR  = 8'h01;
  localparam logic [7:0]  CMD_READ      = 8'h03;
  localparam logic [7:0]  CMD_READ_SR   = 8'h05;

  typedef enum logic [3:0] {
    ST_POWERUP = 4'h1,
    ST_STANDBY = 4'h2,
    ST_ACTIVE  = 4'h4,
    ST_PROGRAM = 4'h8
  } dev_state_t;
endpackage

// ==== hdl/eeprom_sel_ctrl.sv ====
// chip select, serial output and self-timed write cycle control
//
// Operation
// - selected only while chip select low
// - chip select high: standby unless programming
// - started programming cycle always runs to end
// - deselected during programming: standby afterwards
// - output high impedance whenever deselected
// - chip select rise after write starts programming
// - first chip select low required after powerup
// - output bit changes after serial clock fall
// - write cycle lasts at most 6 ms
// - input bits captured on serial clock rise
// - bytes shifted most significant bit first
// - pause low forces output high impedance
`timescale 1ns/1ps
`default_nettype none
module eeprom_sel_ctrl
  import eeprom_sel_pkg::*;
#(
  parameter int unsigned WRITE_CNT = WRITE_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic       si,
  input  wire logic       pause_n,
  input  wire logic       rd_bit,
  output var  logic       so_o,
  output var  logic       so_oe_n,
  output var  logic       standby,
  output var  logic       busy,
  output var  logic       rd_shift,
  output var  logic [7:0] rx_byte,
  output var  logic       rx_valid
);
  import eeprom_sel_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [1:0]       cs_s;
    logic [1:0]       sck_s;
    logic [1:0]       si_s;
    logic [1:0]       pause_s;
    logic             sck_d;
    logic             cs_d;
    dev_state_t       st;
    logic [BIT_CNT_W-1:0] bits;
    logic [7:0]       shreg;
    logic             first_byte;
    logic             wr_latch;
    logic             wr_seq;
    logic [CNT_W-1:0] wcnt;
    logic             so;
    logic             oe_n;
    logic             stby;
    logic             rd_sh;
    logic [7:0]       rxb;
    logic             rxv;
  } state_t;

  state_t s_r, s_nxt;

  logic sel, sck_rise, sck_fall, cs_rise, cs_fall;

  // ==========================================================
  // next state
  always_comb begin
    s_nxt = s_r;
    // pins pass two flops; logic reads the second stage, edge detect also its delayed copy (sck_d, cs_d)
    s_nxt.cs_s    = {s_r.cs_s[0], cs_n};
    s_nxt.sck_s   = {s_r.sck_s[0], sck};
    s_nxt.si_s    = {s_r.si_s[0], si};
    s_nxt.pause_s = {s_r.pause_s[0], pause_n};
    s_nxt.sck_d   = s_r.sck_s[1];
    s_nxt.cs_d    = s_r.cs_s[1];
    s_nxt.rxv     = 1'b0;
    s_nxt.rd_sh   = 1'b0;
    sel      = ~s_r.cs_s[1];
    sck_rise = s_r.sck_s[1] & ~s_r.sck_d;
    sck_fall = ~s_r.sck_s[1] & s_r.sck_d;
    cs_rise  = s_r.cs_s[1] & ~s_r.cs_d;
    cs_fall  = ~s_r.cs_s[1] & s_r.cs_d;

    case (s_r.st)
      ST_POWERUP: begin
        if (sel) begin
          s_nxt.st = ST_STANDBY;
        end
      end
      ST_STANDBY: begin
        if (cs_fall) begin
          s_nxt.st         = ST_ACTIVE;
          s_nxt.bits       = BIT_CNT_RST;
          s_nxt.first_byte = 1'b1;
          s_nxt.wr_seq     = 1'b0;
        end
      end
      ST_ACTIVE: begin
        if (!sel) begin
          // commit on the rising select edge only for a whole write
          if (cs_rise && s_r.wr_seq && s_r.bits == BIT_CNT_RST) begin
            s_nxt.st   = ST_PROGRAM;
            s_nxt.wcnt = '0;
            s_nxt.wr_latch = 1'b0;
          end else begin
            s_nxt.st = ST_STANDBY;
          end
        end else if (s_r.pause_s[1] && sck_rise) begin
          s_nxt.shreg = {s_r.shreg[6:0], s_r.si_s[1]};
          s_nxt.bits  = s_r.bits + 3'h1;
          if (s_r.bits == 3'h7) begin
            s_nxt.rxb = {s_r.shreg[6:0], s_r.si_s[1]};
            s_nxt.rxv = 1'b1;
            s_nxt.first_byte = 1'b0;
            if (s_r.first_byte) begin
              case ({s_r.shreg[6:0], s_r.si_s[1]})
                CMD_WRITE_EN:  s_nxt.wr_latch = 1'b1;
                CMD_WRITE_DIS: s_nxt.wr_latch = 1'b0;
                CMD_WRITE, CMD_WRITE_SR: s_nxt.wr_seq = s_r.wr_latch;
                default: ;
              endcase
            end
          end
        end else if (s_r.pause_s[1] && sck_fall) begin
          s_nxt.so    = rd_bit;
          s_nxt.rd_sh = 1'b1;
        end
      end
      ST_PROGRAM: begin
        // select pin ignored until the timer expires
        s_nxt.wcnt = s_r.wcnt + {{(CNT_W-1){1'b0}}, 1'b1};
        if (s_r.wcnt == CNT_W'(WRITE_CNT - 1)) begin
          s_nxt.st = ST_STANDBY;
        end
      end
      default: s_nxt.st = ST_POWERUP;
    endcase

    s_nxt.oe_n = !(s_nxt.st == ST_ACTIVE && s_r.pause_s[1]);
    s_nxt.stby = (s_nxt.st == ST_STANDBY) || (s_nxt.st == ST_POWERUP);
  end

  // ==========================================================
  // registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '{cs_s: 2'h3, sck_s: 2'h0, si_s: 2'h0, pause_s: 2'h3, sck_d: 1'b0,
               cs_d: 1'b1, st: ST_POWERUP, bits: BIT_CNT_RST, shreg: BYTE_RST,
               first_byte: 1'b1, wr_latch: 1'b0, wr_seq: 1'b0, wcnt: '0,
               so: 1'b0, oe_n: 1'b1, stby: 1'b1, rd_sh: 1'b0, rxb: BYTE_RST,
               rxv: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign so_o     = s_r.so;
  assign so_oe_n  = s_r.oe_n;
  assign standby  = s_r.stby;
  assign busy     = s_r.st[3];   // one-hot program bit, straight from its flop
  assign rd_shift = s_r.rd_sh;
  assign rx_byte  = s_r.rxb;
  assign rx_valid = s_r.rxv;

  // ==========================================================
  // checks
  // the one cycle in which a committing select rise leaves the active state
  sequence commit_seq;
    s_r.st == ST_ACTIVE && s_nxt.st == ST_PROGRAM;
  endsequence

  // a short run of busy cycles: catches a commit that collapses at once
  sequence program_run_seq;
    busy [*8];
  endsequence

  // deselected, not programming and not about to start a write
  sequence desel_idle_seq;
    s_r.cs_s[1] && s_r.st != ST_PROGRAM && s_nxt.st != ST_PROGRAM;
  endsequence

  // a shifting rise that completes a byte
  sequence last_bit_seq;
    s_r.st == ST_ACTIVE && !s_r.cs_s[1] && s_r.pause_s[1] && sck_rise && s_r.bits == 3'h7;
  endsequence

  a_select_drive: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_r.st == ST_ACTIVE && !s_r.cs_s[1] && s_r.pause_s[1] |=> !so_oe_n)
    else $error("output idle while selected");
  a_standby_desel: assert property (@(posedge sys_clk) disable iff (!nrst)
    desel_idle_seq |=> standby)
    else $error("no standby while deselected");
  a_program_holds: assert property (@(posedge sys_clk) disable iff (!nrst)
    commit_seq |=> program_run_seq)
    else $error("program cycle cut short");
  a_busy_holds: assert property (@(posedge sys_clk) disable iff (!nrst)
    busy && s_r.wcnt != CNT_W'(WRITE_CNT - 1) |=> busy)
    else $error("program cycle left early");
  a_program_end: assert property (@(posedge sys_clk) disable iff (!nrst)
    busy && s_r.wcnt == CNT_W'(WRITE_CNT - 1) |=> standby && !busy)
    else $error("no standby after program");
  a_deselect_hiz: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_r.cs_s[1] |=> so_oe_n)
    else $error("output driven while deselected");
  a_commit_cause: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(busy) |-> $past(s_r.cs_s[1]) && $past(s_r.wr_seq) && $past(s_r.bits) == BIT_CNT_RST)
    else $error("write cycle started without a whole write frame");
  a_powerup_wait: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_r.st == ST_POWERUP && s_r.cs_s[1] |=> s_r.st == ST_POWERUP)
    else $error("left powerup without select low");
  a_so_on_fall: assert property (@(posedge sys_clk) disable iff (!nrst)
    $changed(so_o) |-> $past(rd_shift == 1'b0) && rd_shift)
    else $error("output moved off falling edge");
  a_program_bound: assert property (@(posedge sys_clk) disable iff (!nrst)
    busy |-> s_r.wcnt < CNT_W'(WRITE_CNT))
    else $error("write cycle too long");
  a_rx_eighth: assert property (@(posedge sys_clk) disable iff (!nrst)
    last_bit_seq |=> rx_valid)
    else $error("no byte after eighth rise");
  a_byte_order: assert property (@(posedge sys_clk) disable iff (!nrst)
    last_bit_seq |=> rx_byte[0] == $past(s_r.si_s[1]))
    else $error("last bit not in lowest place");
  a_pause_hiz: assert property (@(posedge sys_clk) disable iff (!nrst)
    !s_r.pause_s[1] |=> so_oe_n)
    else $error("output driven while paused");
  a_abandon: assert property (@(posedge sys_clk) disable iff (!nrst)
    cs_fall && s_r.st == ST_STANDBY |=> s_r.bits == BIT_CNT_RST)
    else $error("stale bits");
  a_desel_quiet: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_r.st != ST_ACTIVE |=> !rx_valid && !rd_shift)
    else $error("serial activity outside a frame");
endmodule // eeprom_sel_ctrl
`default_nettype wire

// ==== test/spi_host_model.sv ====
// host bus master model: select, serial clock, data out, data sampling
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input  wire logic sys_clk,
  input  wire logic so_o,
  input  wire logic so_oe_n,
  output var  logic cs_n,
  output var  logic sck,
  output var  logic si
);
  logic last_so = 1'b0;
  logic so_line;
  // released line shows the inverse of its last value, never a stale match
  assign so_line = so_oe_n ? ~last_so : so_o;
  always @(posedge sys_clk) if (!so_oe_n) last_so <= so_o;
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end
  task automatic select(input logic lvl, input int n);
    @(posedge sys_clk) cs_n <= lvl;
    repeat (n) @(posedge sys_clk);
  endtask
  // mode 0: data set while clock low, top n bits msb first, sampled at rise
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      @(posedge sys_clk) si <= tx[i];
      repeat (12) @(posedge sys_clk);
      sck <= 1'b1;
      rx[i] = so_line;
      repeat (12) @(posedge sys_clk);
      sck <= 1'b0;
    end
  endtask
endmodule // spi_host_model
`default_nettype wire

// ==== test/spi_eeprom_select_output_ctrl_tb_top.sv ====
// self-checking bench for select, serial output and write-cycle control
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_select_output_ctrl_tb_top;
  import eeprom_sel_pkg::*;
  localparam int unsigned WCNT = 50;
  localparam int CYC_LIMIT = 20000;
  localparam logic [15:0] PAT = 16'hA5C3;
  logic sys_clk = 1'b0, nrst = 1'b0, pause_n = 1'b1, rd_bit = 1'b0;
  logic cs_n, sck, si, so_o, so_oe_n, standby, busy, rd_shift, rx_valid;
  logic [7:0]  rx_byte, rx;
  logic [15:0] pat = PAT;
  int fail_count = 0, n_compared = 0, rx_cnt = 0, cyc = 0, n;
  eeprom_sel_ctrl #(.WRITE_CNT(WCNT)) eeprom_sel_ctrl_inst (.sys_clk(sys_clk), .nrst(nrst), .cs_n(cs_n),
    .sck(sck), .si(si), .pause_n(pause_n), .rd_bit(rd_bit), .so_o(so_o), .so_oe_n(so_oe_n),
    .standby(standby), .busy(busy), .rd_shift(rd_shift), .rx_byte(rx_byte), .rx_valid(rx_valid));
  spi_host_model spi_host_model_inst (.sys_clk(sys_clk), .so_o(so_o), .so_oe_n(so_oe_n),
    .cs_n(cs_n), .sck(sck), .si(si));
  initial forever #2.5 sys_clk = ~sys_clk;
  // user side feeds read bits msb first, advancing on each shift request
  always @(posedge sys_clk) begin
    cyc++;
    if (rx_valid === 1'b1) rx_cnt++;
    if (rd_shift === 1'b1) pat <= {pat[14:0], pat[15]};
    rd_bit <= pat[15];
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic frame(input logic [7:0] b, input int bits);
    spi_host_model_inst.select(1'b0, 30);
    spi_host_model_inst.xfer(b, bits, rx);
    spi_host_model_inst.select(1'b1, 30);
  endtask
  task automatic t_idle();
    check("standby", 8'h1, {7'h0, standby});
    spi_host_model_inst.xfer(8'hA5, 8, rx);
    check("rx count", 8'h0, rx_cnt[7:0]);
    spi_host_model_inst.select(1'b0, 30);
    // first low after powerup only arms the device; this frame is not taken
    spi_host_model_inst.xfer(8'h5A, 8, rx);
    check("rx count powerup", 8'h0, rx_cnt[7:0]);
    spi_host_model_inst.select(1'b1, 30);
  endtask
  task automatic t_rx();
    spi_host_model_inst.select(1'b0, 30);
    check("oe_n sel", 8'h0, {7'h0, so_oe_n});
    spi_host_model_inst.xfer(8'hA5, 8, rx);
    spi_host_model_inst.select(1'b1, 30);
    check("rx byte", 8'hA5, rx_byte);
    check("oe_n desel", 8'h1, {7'h0, so_oe_n});
    check("standby", 8'h1, {7'h0, standby});
  endtask
  task automatic t_partial();
    n = rx_cnt;
    frame(8'hF0, 4);
    frame(8'h3C, 8);
    check("rx count", 8'(n + 1), rx_cnt[7:0]);
    check("rx byte", 8'h3C, rx_byte);
  endtask
  task automatic t_pause();
    n = rx_cnt;
    spi_host_model_inst.select(1'b0, 30);
    pause_n <= 1'b0;
    spi_host_model_inst.xfer(8'hFF, 8, rx);
    check("oe_n paused", 8'h1, {7'h0, so_oe_n});
    check("rx count", 8'(n), rx_cnt[7:0]);
    pause_n <= 1'b1;
    spi_host_model_inst.select(1'b1, 30);
  endtask
  task automatic t_read();
    logic [15:0] p0;
    p0 = pat;
    spi_host_model_inst.select(1'b0, 30);
    spi_host_model_inst.xfer(CMD_READ, 8, rx);
    spi_host_model_inst.xfer(8'h00, 8, rx);
    spi_host_model_inst.select(1'b1, 30);
    check("read byte", p0[8:1], rx);
  endtask
  task automatic t_write();
    frame(CMD_WRITE, 8);
    check("busy no latch", 8'h0, {7'h0, busy});
    frame(CMD_WRITE_EN, 8);
    frame(CMD_WRITE_DIS, 8);
    frame(CMD_WRITE, 8);
    check("busy latch off", 8'h0, {7'h0, busy});
    frame(CMD_WRITE_EN, 8);
    spi_host_model_inst.select(1'b0, 30);
    spi_host_model_inst.xfer(CMD_WRITE, 8, rx);
    spi_host_model_inst.xfer(8'h5A, 4, rx);
    spi_host_model_inst.select(1'b1, 30);
    check("busy part byte", 8'h0, {7'h0, busy});
    frame(CMD_WRITE_SR, 8);
    check("busy status", 8'h1, {7'h0, busy});
    n = 0;
    while (busy === 1'b1 && n < 2 * WCNT) begin
      @(posedge sys_clk);
      n++;
    end
    // frame returns 31 edges after it raised select
    check("status write len", 8'h1, {7'h0, n + 31 >= WCNT && n + 31 <= WCNT + 5});
    frame(CMD_WRITE_EN, 8);
    spi_host_model_inst.select(1'b0, 30);
    spi_host_model_inst.xfer(CMD_WRITE, 8, rx);
    spi_host_model_inst.xfer(8'h5A, 8, rx);
    spi_host_model_inst.select(1'b1, 5);
    check("busy", 8'h1, {7'h0, busy});
    check("standby busy", 8'h0, {7'h0, standby});
    spi_host_model_inst.select(1'b0, 5);
    spi_host_model_inst.select(1'b1, 5);
    n = 18;
    while (busy === 1'b1 && n < 2 * WCNT) begin
      @(posedge sys_clk);
      n++;
    end
    check("write len ok", 8'h1, {7'h0, n >= WCNT && n <= WCNT + 5});
    @(posedge sys_clk);
    check("standby after", 8'h1, {7'h0, standby});
  endtask
  // reset in the middle of a write cycle, then the powerup select rule again
  task automatic t_reset();
    frame(CMD_WRITE_EN, 8);
    frame(CMD_WRITE, 8);
    check("busy before reset", 8'h1, {7'h0, busy});
    nrst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check("oe_n in reset", 8'h1, {7'h0, so_oe_n});
    check("standby in reset", 8'h1, {7'h0, standby});
    nrst <= 1'b1;
    n = rx_cnt;
    frame(8'hA5, 8);
    check("rx count reset", 8'(n), rx_cnt[7:0]);
    frame(8'h3C, 8);
    check("rx count after", 8'(n + 1), rx_cnt[7:0]);
    check("rx byte after", 8'h3C, rx_byte);
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    fork
      begin
        t_idle();
        t_rx();
        t_partial();
        t_pause();
        t_read();
        t_write();
        t_reset();
      end
      begin
        wait (cyc >= CYC_LIMIT);
        fail_count++;
        $display("MISMATCH cycle limit expected below %0d seen %0d", CYC_LIMIT, cyc);
      end
    join_any
    give_verdict();
  end
endmodule // spi_eeprom_select_output_ctrl_tb_top
`default_nettype wire
